// *** amc_mode_ctrl.sv ***
// operating-mode register, conversion sequencer and serial port of the converter
`timescale 1ns/1ps

// Notes on behaviour
// - eight-bit mode register, writable and readable serially
// - mode register select code 01, resets 0x02
// - mode register shifts MSB first
// - mode write resets converter, sets ready flag
// - mode register field layout and reset values
// - continuous mode stores results, ready goes low
// - continuous read shifts results without commands
// - first result after two periods, then one
// - single conversion: two periods, then power down
// - mode field encodes continuous, reserved, single, power-down
// - buffer bit selects buffered analog input
// - polarity bit selects straight or offset binary
// - burnout only when enabled and buffer active
module amc_mode_ctrl #(
    parameter int CONV_CYCLES = amc_pkg::CONV_CYCLES,
    parameter bit WORD_24     = 1'b1
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               sclk,
    input  wire logic               din,
    input  wire logic               cs_n,
    output logic                    dout_rdy_o,
    output logic                    dout_rdy_oe,
    input  wire logic [23:0]        sample_in,
    output amc_pkg::amc_front_t     front,
    output logic                    modulator_reset
);

    // ==========================================================
    // pin synchronisers and sclk edge detection
    logic       sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
    logic       din_s1_ff,  din_s2_ff;
    logic       cs_s1_ff,   cs_s2_ff;
    logic       rise;
    logic       fall;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_s1_ff <= 1'b1;
            sclk_s2_ff <= 1'b1;
            sclk_s3_ff <= 1'b1;
            din_s1_ff  <= 1'b0;
            din_s2_ff  <= 1'b0;
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
        end else if (ce) begin
            sclk_s1_ff <= sclk;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            din_s1_ff  <= din;
            din_s2_ff  <= din_s1_ff;
            cs_s1_ff   <= cs_n;
            cs_s2_ff   <= cs_s1_ff;
        end
    end

    // host samples dout on the rising edge; we move dout just after it
    assign rise = sclk_s2_ff & ~sclk_s3_ff;
    assign fall = ~sclk_s2_ff & sclk_s3_ff;

    // ==========================================================
    // state declarations
    amc_pkg::amc_ser_t  ser_ff;
    amc_pkg::amc_cv_t   cv_ff;
    logic [7:0]         mode_ff;
    logic [7:0]         sh_ff;
    logic [1:0]         rs_ff;
    logic [4:0]         bit_ff;
    logic [4:0]         last_ff;
    logic [23:0]        out_ff;
    logic               shifting_ff;
    logic               cread_ff;
    logic               rdy_ff;
    logic               pin_ff;
    logic               crd_wait_ff;
    logic [23:0]        data_ff;
    logic [23:0]        cnt_ff;
    logic [1:0]         per_ff;
    logic [23:0]        fifo_mem [2];
    logic               wp_ff, rp_ff;
    logic [1:0]         fcnt_ff;

    logic [7:0]         cmd_byte;
    logic [7:0]         wr_byte;
    logic               cmd_done;
    logic               mode_wr;
    logic [1:0]         new_md;
    logic               push_valid, push_ready, pop_valid, pop;
    logic               crd_load, data_cmd;
    logic [23:0]        result;
    logic               period_end;

    assign cmd_byte = {sh_ff[6:0], din_s2_ff};
    assign wr_byte  = cmd_byte;
    assign cmd_done = (ser_ff == amc_pkg::SER_CMD) && rise && !cs_s2_ff
                      && (bit_ff == amc_pkg::LAST_BYTE)
                      && !cmd_byte[amc_pkg::COMM_WEN_N];
    assign mode_wr  = (ser_ff == amc_pkg::SER_WR) && rise && !cs_s2_ff
                      && (bit_ff == amc_pkg::LAST_BYTE) && (rs_ff == amc_pkg::REG_MODE);
    assign data_cmd = cmd_done && cmd_byte[amc_pkg::COMM_READ]
                      && (cmd_byte[amc_pkg::COMM_RS_HI:amc_pkg::COMM_RS_LO]
                          == amc_pkg::REG_DATA);
    assign crd_load = (ser_ff == amc_pkg::SER_CRD) && !cs_s2_ff && !shifting_ff
                      && pop_valid;
    assign pop      = pop_valid && (data_cmd || crd_load);
    assign modulator_reset = mode_wr;

    // ==========================================================
    // operating-mode register
    // reserved mode code leaves the conversion mode as it was
    assign new_md = (wr_byte[7:6] == amc_pkg::MD_RSVD) ? mode_ff[7:6] : wr_byte[7:6];

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ff <= amc_pkg::MODE_RESET;
        end else if (ce && mode_wr) begin
            // bits 5:4 and 0 are held at zero whatever the host sends
            mode_ff <= {new_md, 2'h0, wr_byte[3:1], 1'h0};
        end
    end

    assign front.buffer_en  = mode_ff[amc_pkg::MODE_BUF];
    assign front.burnout_en = mode_ff[amc_pkg::MODE_BO] & mode_ff[amc_pkg::MODE_BUF];
    assign front.unipolar   = mode_ff[amc_pkg::MODE_UB];
    assign front.converting = (cv_ff != amc_pkg::CV_OFF);

    // ==========================================================
    // conversion sequencer
    assign period_end = (cv_ff == amc_pkg::CV_RUN) && (cnt_ff == 24'(CONV_CYCLES - 1));
    assign result     = mode_ff[amc_pkg::MODE_UB] ? sample_in
                        : (sample_in ^ amc_pkg::BIP_OFFSET);
    assign push_valid = (cv_ff == amc_pkg::CV_HOLD);

    always_ff @(posedge clk) begin
        if (rst) begin
            cv_ff  <= amc_pkg::CV_RUN;
            cnt_ff <= 24'h000000;
            per_ff <= amc_pkg::FIRST_PERIODS;
        end else if (ce) begin
            if (mode_wr) begin
                cnt_ff <= 24'h000000;
                per_ff <= amc_pkg::FIRST_PERIODS;
                cv_ff  <= (new_md == amc_pkg::MD_PDOWN) ? amc_pkg::CV_OFF
                                                        : amc_pkg::CV_RUN;
            end else begin
                case (cv_ff)
                    amc_pkg::CV_RUN: begin
                        if (period_end) begin
                            cnt_ff <= 24'h000000;
                            if (per_ff == amc_pkg::NEXT_PERIODS) begin
                                cv_ff <= amc_pkg::CV_HOLD;
                            end else begin
                                per_ff <= per_ff - 2'h1;
                            end
                        end else begin
                            cnt_ff <= cnt_ff + 24'h000001;
                        end
                    end
                    amc_pkg::CV_HOLD: begin
                        // a full buffer stalls the modulator instead of losing a word
                        if (push_ready) begin
                            per_ff <= amc_pkg::NEXT_PERIODS;
                            cv_ff  <= (mode_ff[7:6] == amc_pkg::MD_CONT) ? amc_pkg::CV_RUN
                                                                         : amc_pkg::CV_OFF;
                        end
                    end
                    amc_pkg::CV_OFF: begin
                        cnt_ff <= 24'h000000;
                    end
                    default: begin
                        cv_ff <= amc_pkg::CV_OFF;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // two-entry result buffer standing in for the data register
    assign push_ready = (fcnt_ff != 2'h2);
    assign pop_valid  = (fcnt_ff != 2'h0);

    always_ff @(posedge clk) begin
        if (rst || (ce && mode_wr)) begin
            wp_ff   <= 1'b0;
            rp_ff   <= 1'b0;
            fcnt_ff <= 2'h0;
        end else if (ce) begin
            if (push_valid && push_ready) begin
                fifo_mem[wp_ff] <= result;
                wp_ff           <= ~wp_ff;
            end
            if (pop) begin
                rp_ff <= ~rp_ff;
            end
            fcnt_ff <= fcnt_ff + 2'(push_valid && push_ready) - 2'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            data_ff <= amc_pkg::DATA_RESET;
        end else if (ce && pop) begin
            data_ff <= fifo_mem[rp_ff];
        end
    end

    // ready flag: low while an unread result waits
    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_ff <= 1'b1;
        end else if (ce) begin
            if (mode_wr || cv_ff == amc_pkg::CV_OFF && !pop_valid) begin
                rdy_ff <= 1'b1;
            end else if (pop_valid && !pop) begin
                rdy_ff <= 1'b0;
            end else begin
                rdy_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // serial port: command byte, register write, register read
    always_ff @(posedge clk) begin
        if (rst) begin
            ser_ff      <= amc_pkg::SER_CMD;
            sh_ff       <= 8'h00;
            rs_ff       <= amc_pkg::REG_COMM;
            bit_ff      <= 5'h00;
            last_ff     <= amc_pkg::LAST_BYTE;
            out_ff      <= 24'h000000;
            shifting_ff <= 1'b0;
            cread_ff    <= 1'b0;
        end else if (ce) begin
            if (cs_s2_ff) begin
                // deselect ends any frame, continuous read included
                ser_ff      <= amc_pkg::SER_CMD;
                bit_ff      <= 5'h00;
                shifting_ff <= 1'b0;
                cread_ff    <= 1'b0;
            end else begin
                case (ser_ff)
                    amc_pkg::SER_CMD: begin
                        if (rise) begin
                            sh_ff  <= cmd_byte;
                            bit_ff <= bit_ff + 5'h01;
                            if (bit_ff == amc_pkg::LAST_BYTE) begin
                                bit_ff <= 5'h00;
                            end
                        end
                        if (cmd_done) begin
                            rs_ff <= cmd_byte[amc_pkg::COMM_RS_HI:amc_pkg::COMM_RS_LO];
                            if (!cmd_byte[amc_pkg::COMM_READ]) begin
                                ser_ff <= amc_pkg::SER_WR;
                            end else begin
                                shifting_ff <= 1'b1;
                                last_ff     <= amc_pkg::LAST_BYTE;
                                ser_ff      <= amc_pkg::SER_RD;
                                case (cmd_byte[amc_pkg::COMM_RS_HI:amc_pkg::COMM_RS_LO])
                                    amc_pkg::REG_COMM: begin
                                        out_ff <= {amc_pkg::STAT_FIXED
                                                   | (8'(rdy_ff) << amc_pkg::STAT_RDY)
                                                   | (8'(WORD_24) << amc_pkg::STAT_WL),
                                                   16'h0000};
                                    end
                                    amc_pkg::REG_MODE: begin
                                        out_ff <= {mode_ff, 16'h0000};
                                    end
                                    amc_pkg::REG_FILT: begin
                                        out_ff <= {amc_pkg::FILT_VALUE, 16'h0000};
                                    end
                                    default: begin
                                        // a command read drains one result
                                        out_ff  <= pop_valid ? fifo_mem[rp_ff] : data_ff;
                                        last_ff <= amc_pkg::LAST_WORD;
                                        if (cmd_byte[amc_pkg::COMM_CREAD]) begin
                                            cread_ff <= 1'b1;
                                            ser_ff   <= amc_pkg::SER_CRD;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                    amc_pkg::SER_WR: begin
                        if (rise) begin
                            sh_ff  <= cmd_byte;
                            bit_ff <= bit_ff + 5'h01;
                            if (bit_ff == amc_pkg::LAST_BYTE) begin
                                bit_ff <= 5'h00;
                                ser_ff <= amc_pkg::SER_CMD;
                            end
                        end
                    end
                    amc_pkg::SER_RD, amc_pkg::SER_CRD: begin
                        if (crd_load) begin
                            out_ff      <= fifo_mem[rp_ff];
                            shifting_ff <= 1'b1;
                            bit_ff      <= 5'h00;
                        end else if (rise && shifting_ff) begin
                            out_ff <= {out_ff[22:0], 1'b0};
                            bit_ff <= bit_ff + 5'h01;
                            if (bit_ff == last_ff) begin
                                bit_ff      <= 5'h00;
                                shifting_ff <= 1'b0;
                                if (!cread_ff) begin
                                    ser_ff <= amc_pkg::SER_CMD;
                                end
                            end
                        end
                    end
                    default: begin
                        ser_ff <= amc_pkg::SER_CMD;
                    end
                endcase
            end
        end
    end

    // continuous read pops a result at once when no word is shifting, so the ready flag then stays high;
    // the pin is held low instead until the host lowers sclk for the first bit
    always_ff @(posedge clk) begin
        if (rst) begin
            crd_wait_ff <= 1'b0;
        end else if (ce) begin
            if (cs_s2_ff || fall) begin
                crd_wait_ff <= 1'b0;
            end else if (crd_load) begin
                crd_wait_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // output pin: low during the continuous-read wait, else data bit while shifting, else the ready level
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_ff <= 1'b1;
        end else if (ce) begin
            pin_ff <= crd_wait_ff ? 1'b0 : (shifting_ff ? out_ff[23] : rdy_ff);
        end
    end

    assign dout_rdy_o  = pin_ff;
    assign dout_rdy_oe = !cs_s2_ff;

    // ==========================================================
    // checks
    sequence s_mode_write;
        mode_wr && ce;
    endsequence

    property p_reset_value;
        @(posedge clk) rst |=> (mode_ff == amc_pkg::MODE_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("mode reset value wrong");

    property p_write_rdy;
        @(posedge clk) disable iff (rst) s_mode_write |=> rdy_ff && (fcnt_ff == 2'h0);
    endproperty
    a_write_rdy: assert property (p_write_rdy) else $error("mode write kept a result");

    property p_zero_bits;
        @(posedge clk) disable iff (rst) s_mode_write |=> (mode_ff[5:4] == 2'h0) && !mode_ff[0];
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("fixed mode bits not zero");

    property p_burnout;
        @(posedge clk) disable iff (rst) front.burnout_en |-> mode_ff[amc_pkg::MODE_BUF];
    endproperty
    a_burnout: assert property (p_burnout) else $error("burnout without buffer");

    property p_reserved;
        @(posedge clk) disable iff (rst)
            s_mode_write ##0 (wr_byte[7:6] == amc_pkg::MD_RSVD) |=> $stable(mode_ff[7:6]);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode taken");

    property p_first_period;
        @(posedge clk) disable iff (rst || !ce || mode_wr)
            period_end && per_ff == amc_pkg::FIRST_PERIODS |=> cv_ff == amc_pkg::CV_RUN
                && per_ff == amc_pkg::NEXT_PERIODS && cnt_ff == 24'h000000;
    endproperty
    a_first_period: assert property (p_first_period) else $error("first period skipped");

    property p_single_off;
        @(posedge clk) disable iff (rst || !ce || mode_wr)
            push_valid && push_ready && mode_ff[7:6] == amc_pkg::MD_SINGLE
            |=> cv_ff == amc_pkg::CV_OFF;
    endproperty
    a_single_off: assert property (p_single_off) else $error("single mode kept running");

    property p_msb_first;
        @(posedge clk) disable iff (rst || !ce || cs_s2_ff)
            cmd_done && cmd_byte[amc_pkg::COMM_READ] |=> ##1 dout_rdy_o == out_ff[23];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

    property p_rdy_low;
        @(posedge clk) disable iff (rst || !ce)
            pop_valid && !pop && !mode_wr |=> !rdy_ff;
    endproperty
    a_rdy_low: assert property (p_rdy_low) else $error("ready not low with result");

    property p_crd_ready;
        @(posedge clk) disable iff (rst || !ce || cs_s2_ff)
            crd_load && !fall |=> ##1 !dout_rdy_o;
    endproperty
    a_crd_ready: assert property (p_crd_ready) else $error("no ready in continuous read");

endmodule : amc_mode_ctrl

// *** amc_pkg.sv ***
// package for the converter operating-mode control block
package amc_pkg;

    // ==========================================================
    // register select codes
    localparam logic [1:0] REG_COMM   = 2'h0;
    localparam logic [1:0] REG_MODE   = 2'h1;
    localparam logic [1:0] REG_FILT   = 2'h2;
    localparam logic [1:0] REG_DATA   = 2'h3;

    // ==========================================================
    // operating-mode register layout and reset value
    localparam logic [7:0] MODE_RESET = 8'h02;
    localparam int         MODE_MD_HI = 7;
    localparam int         MODE_MD_LO = 6;
    localparam int         MODE_BO    = 3;
    localparam int         MODE_UB    = 2;
    localparam int         MODE_BUF   = 1;
    localparam logic [1:0] MD_CONT    = 2'h0;
    localparam logic [1:0] MD_RSVD    = 2'h1;
    localparam logic [1:0] MD_SINGLE  = 2'h2;
    localparam logic [1:0] MD_PDOWN   = 2'h3;

    // ==========================================================
    // command byte layout
    localparam int         COMM_WEN_N = 7;
    localparam int         COMM_RS_HI = 5;
    localparam int         COMM_RS_LO = 4;
    localparam int         COMM_READ  = 3;
    localparam int         COMM_CREAD = 2;

    // ==========================================================
    // status byte constant part and other read values
    localparam logic [7:0] STAT_FIXED = 8'h08;
    localparam int         STAT_RDY   = 7;
    localparam int         STAT_WL    = 2;
    localparam logic [7:0] FILT_VALUE = 8'h00;
    localparam logic [4:0] LAST_BYTE  = 5'h07;
    localparam logic [4:0] LAST_WORD  = 5'h17;

    // ==========================================================
    // result coding and conversion timing
    localparam logic [23:0] BIP_OFFSET   = 24'h800000;
    localparam logic [23:0] DATA_RESET   = 24'h000000;
    localparam int          CLK_NS       = 10;
    localparam int          CONV_NS      = 100000;
    localparam int          CONV_CYCLES  = CONV_NS / CLK_NS;
    localparam logic [1:0]  FIRST_PERIODS = 2'h2;
    localparam logic [1:0]  NEXT_PERIODS  = 2'h1;

    typedef enum logic [3:0] {
        SER_CMD = 4'h1,
        SER_WR  = 4'h2,
        SER_RD  = 4'h4,
        SER_CRD = 4'h8
    } amc_ser_t;

    typedef enum logic [2:0] {
        CV_OFF  = 3'h1,
        CV_RUN  = 3'h2,
        CV_HOLD = 3'h4
    } amc_cv_t;

    typedef struct packed {
        logic       buffer_en;
        logic       burnout_en;
        logic       unipolar;
        logic       converting;
    } amc_front_t;

endpackage : amc_pkg

// *** amc_host_model.sv ***
// host-side model of the four-wire serial port of the converter
`timescale 1ns/1ps
module amc_host_model #(
    parameter int HALF = 8
) (
    input  wire logic clk,
    output logic      sclk,
    output logic      din,
    output logic      cs_n,
    input  wire logic dout_rdy_o,
    input  wire logic dout_rdy_oe,
    output logic      pin
);
    logic last_ff;

    // a released pin shows the inverse of its last level, so a stale value never passes
    assign pin = dout_rdy_oe ? dout_rdy_o : ~last_ff;

    always @(posedge clk) begin
        if (dout_rdy_oe) begin
            last_ff <= dout_rdy_o;
        end
    end

    initial begin
        last_ff = 1'b1;
        sclk = 1'b1;
        din = 1'b1;
        cs_n = 1'b1;
    end

    // ==========================================================
    // bit and frame tasks
    task automatic select(input logic level);
        @(posedge clk);
        cs_n <= level;
        // the select passes a synchroniser before it takes effect
        repeat (4) @(posedge clk);
    endtask : select

    task automatic bit_io(input logic tx, output logic rx);
        @(posedge clk);
        sclk <= 1'b0;
        din <= tx;
        repeat (HALF - 1) @(posedge clk);
        @(negedge clk);
        rx = pin;
        @(posedge clk);
        sclk <= 1'b1;
        repeat (HALF - 1) @(posedge clk);
    endtask : bit_io

    task automatic xfer8(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask : xfer8

    task automatic rd24(output logic [23:0] rx);
        for (int i = 23; i >= 0; i--) begin
            bit_io(1'b1, rx[i]);
        end
    endtask : rd24

    // ==========================================================
    // register access
    task automatic write_mode(input logic [7:0] val);
        logic [7:0] unused;
        select(1'b0);
        xfer8({2'h0, amc_pkg::REG_MODE, 4'h0}, unused);
        xfer8(val & 8'hCE, unused);
        select(1'b1);
    endtask : write_mode

    task automatic read8(input logic [1:0] rs, output logic [7:0] rx);
        logic [7:0] unused;
        select(1'b0);
        xfer8({2'h0, rs, 4'h8}, unused);
        xfer8(8'hFF, rx);
        select(1'b1);
    endtask : read8

    task automatic read_data(output logic [23:0] rx);
        logic [7:0] unused;
        select(1'b0);
        xfer8({2'h0, amc_pkg::REG_DATA, 4'h8}, unused);
        rd24(rx);
        select(1'b1);
    endtask : read_data
endmodule : amc_host_model

// *** amc_mode_ctrl_test.sv ***
// self-checking bench for the operating-mode control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR %0t got %h expected %h", $time, got, exp); end end
module amc_mode_ctrl_test;
    localparam int CONV = 1000;

    logic                clk = 1'b0;
    logic                rst;
    logic                ce;
    logic                sclk;
    logic                din;
    logic                cs_n;
    logic                dout_rdy_o;
    logic                dout_rdy_oe;
    logic                pin;
    logic [23:0]         sample_in;
    amc_pkg::amc_front_t front;
    logic                modulator_reset;
    logic [7:0]          b8;
    logic [23:0]         b24;
    int                  bad_count = 0;
    int                  checks_done = 0;
    int                  cyc = 0;
    int                  mr_cnt = 0;
    int                  mr_cyc = 0;
    int                  t1;
    int                  t2;

    always #5 clk = ~clk;

    amc_mode_ctrl #(.CONV_CYCLES(CONV), .WORD_24(1'b1)) i_amc_mode_ctrl (
        .clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .din(din), .cs_n(cs_n),
        .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe), .sample_in(sample_in),
        .front(front), .modulator_reset(modulator_reset));

    amc_host_model i_amc_host_model (
        .clk(clk), .sclk(sclk), .din(din), .cs_n(cs_n),
        .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe), .pin(pin));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (modulator_reset === 1'b1) begin
            mr_cnt <= mr_cnt + 1;
            mr_cyc <= cyc;
        end
    end

    task automatic stop_test();
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    // select must be low: the pin then shows the ready level
    task automatic wait_low(output int t);
        int n;
        n = 0;
        while (pin !== 1'b0 && n < 4 * CONV) begin
            @(negedge clk);
            n++;
        end
        `CHK(pin, 1'b0)
        t = cyc;
    endtask : wait_low

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        stop_test();
    end

    initial begin
        rst <= 1'b1;
        ce <= 1'b1;
        sample_in <= 24'h123456;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        i_amc_host_model.read8(amc_pkg::REG_MODE, b8);
        `CHK(b8, amc_pkg::MODE_RESET)
        `CHK(front, 4'h9)
        i_amc_host_model.write_mode(8'h0E);
        `CHK(mr_cnt, 1)
        i_amc_host_model.read8(amc_pkg::REG_MODE, b8);
        `CHK(b8, 8'h0E)
        `CHK(front, 4'hF)
        i_amc_host_model.read8(amc_pkg::REG_COMM, b8);
        `CHK(b8, 8'h8C)
        i_amc_host_model.write_mode(8'h08);
        i_amc_host_model.read8(amc_pkg::REG_MODE, b8);
        `CHK(b8, 8'h08)
        `CHK(front, 4'h1)
        // continuous conversion with continuous read, bipolar coding
        i_amc_host_model.write_mode(8'h02);
        i_amc_host_model.select(1'b0);
        wait_low(t1);
        `CHK((t1 - mr_cyc >= 2 * CONV) && (t1 - mr_cyc <= 2 * CONV + 4), 1'b1)
        @(posedge clk);
        sample_in <= 24'h00ABCD;
        i_amc_host_model.xfer8({2'h0, amc_pkg::REG_DATA, 4'hC}, b8);
        i_amc_host_model.rd24(b24);
        `CHK(b24, 24'h923456)
        wait_low(t2);
        `CHK((t2 - t1 >= CONV + 1) && (t2 - t1 <= CONV + 3), 1'b1)
        i_amc_host_model.rd24(b24);
        `CHK(b24, 24'h80ABCD)
        i_amc_host_model.select(1'b1);
        i_amc_host_model.write_mode(8'h06);
        i_amc_host_model.select(1'b0);
        // a low enable freezes the sequencer, so the first result slips by as much
        @(posedge clk);
        ce <= 1'b0;
        repeat (500) @(posedge clk);
        `CHK(pin, 1'b1)
        ce <= 1'b1;
        wait_low(t1);
        `CHK((t1 - mr_cyc >= 2 * CONV + 500) && (t1 - mr_cyc <= 2 * CONV + 505), 1'b1)
        i_amc_host_model.select(1'b1);
        i_amc_host_model.read_data(b24);
        `CHK(b24, 24'h00ABCD)
        // single conversion, then power-down and a reserved code
        i_amc_host_model.write_mode(8'h82);
        i_amc_host_model.select(1'b0);
        wait_low(t1);
        `CHK((t1 - mr_cyc >= 2 * CONV) && (t1 - mr_cyc <= 2 * CONV + 4), 1'b1)
        repeat (4) @(posedge clk);
        `CHK(front.converting, 1'b0)
        i_amc_host_model.select(1'b1);
        i_amc_host_model.read8(amc_pkg::REG_MODE, b8);
        `CHK(b8, 8'h82)
        i_amc_host_model.write_mode(8'hC2);
        `CHK(front.converting, 1'b0)
        i_amc_host_model.write_mode(8'h46);
        i_amc_host_model.read8(amc_pkg::REG_MODE, b8);
        `CHK(b8, 8'hC6)
        // a second reset in mid-run brings the defaults back
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        i_amc_host_model.read8(amc_pkg::REG_MODE, b8);
        `CHK(b8, amc_pkg::MODE_RESET)
        `CHK(front, 4'h9)
        stop_test();
    end
endmodule : amc_mode_ctrl_test
